//--- common/dma_pkg.sv
// Shared constants and carrier types for the multichannel transfer interface
// Assumes one core clock at 40 MHz and synchronous active-high reset
package dma_pkg;
   localparam int NUM_CHAN = 6;
   localparam int NUM_STREAM = 4;
   localparam int NARROW_W = 16;
   localparam int WIDE_W = 32;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CHAN_W = 3;
   localparam logic [CHAN_W-1:0] CHAN_AI = 3'h0;
   localparam logic [CHAN_W-1:0] CHAN_AO = 3'h1;
   localparam logic [CHAN_W-1:0] CHAN_CTR0 = 3'h2;
   localparam logic [CHAN_W-1:0] CHAN_CTR1 = 3'h3;
   localparam logic [CHAN_W-1:0] CHAN_DO = 3'h4;
   localparam logic [CHAN_W-1:0] CHAN_DI = 3'h5;
   // Input channels move data toward the host, output channels away from it
   localparam logic [NUM_CHAN-1:0] CHAN_IS_INPUT = 6'h2d;
   localparam logic [2:0] STREAM_NONE = 3'h7;

   typedef enum logic [1:0] {
      XFER_DMA = 2'b00,
      XFER_IRQ = 2'b01,
      XFER_PIO = 2'b10
   } xfer_mode_type;

   typedef struct packed {
      logic valid;
      logic [NARROW_W-1:0] data;
   } narrow_beat_type;

   typedef struct packed {
      logic valid;
      logic last;
      logic [WIDE_W-1:0] data;
      logic [3:0] byte_en;
   } wide_beat_type;
endpackage

//--- design/dma_host_if.sv
// Six packing DMA channels, interrupt fallback and four granted stream slots
// Assumes one clock, synchronous inputs, host side presents bursts as beats
`timescale 1ns/1ps
// Overview of operation
// - Six independent channels, one per acquisition block
// - Each channel owns a FIFO, separate fill/drain
// - Bursts into and out of every FIFO
// - Pack two 16-bit words per 32-bit word
// - Unaligned host buffers handled by byte enables on output channels only; input channels always send all four bytes
// - DMA by default; disable selects interrupts
// - Interrupt mode raises request; service clears it only once the channel is not ready or DMA is re-enabled
// - Stream slots move data without microcontroller
// - Four stream slots granted on request; lowest channel wins when several ask at once
// - No free slot: refuse and flag error
module dma_host_if import dma_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Per-channel control
   input wire logic [NUM_CHAN-1:0] dma_disable,
   input wire logic [NUM_CHAN-1:0] irq_service,
   output logic [NUM_CHAN-1:0] irq_req,
   // Acquisition side, narrow words
   input narrow_beat_type [NUM_CHAN-1:0] acq_in,
   output logic [NUM_CHAN-1:0] acq_in_ready,
   output narrow_beat_type [NUM_CHAN-1:0] acq_out,
   input wire logic [NUM_CHAN-1:0] acq_out_ready,
   // Host side, wide words
   input wide_beat_type [NUM_CHAN-1:0] host_in,
   output logic [NUM_CHAN-1:0] host_in_ready,
   output wide_beat_type [NUM_CHAN-1:0] host_out,
   input wire logic [NUM_CHAN-1:0] host_out_ready,
   // Stream slot allocation
   input wire logic [NUM_CHAN-1:0] stream_req,
   input wire logic [NUM_CHAN-1:0] stream_release,
   output logic [NUM_CHAN-1:0] stream_grant,
   output logic [NUM_CHAN-1:0] stream_error
);
   logic [WIDE_W-1:0] mem_q [NUM_CHAN][FIFO_DEPTH];
   logic [PTR_W:0] wr_q [NUM_CHAN];
   logic [PTR_W:0] wr_d [NUM_CHAN];
   logic [PTR_W:0] rd_q [NUM_CHAN];
   logic [PTR_W:0] rd_d [NUM_CHAN];
   logic [NUM_CHAN-1:0] half_q, half_d;
   logic [NARROW_W-1:0] hold_q [NUM_CHAN];
   logic [NARROW_W-1:0] hold_d [NUM_CHAN];
   logic [NUM_CHAN-1:0] full, empty, push, pop;
   logic [WIDE_W-1:0] push_data [NUM_CHAN];
   narrow_beat_type [NUM_CHAN-1:0] acq_out_d, acq_out_q;
   wide_beat_type [NUM_CHAN-1:0] host_out_d, host_out_q;
   logic [NUM_CHAN-1:0] irq_d, irq_q;
   logic [2:0] slot_q [NUM_STREAM];
   logic [2:0] slot_d [NUM_STREAM];
   logic [NUM_CHAN-1:0] grant_d, grant_q, err_d, err_q;
   // Byte enables of a full host word and of its upper half only
   localparam logic [3:0] BE_ALL = 4'hf;
   localparam logic [3:0] BE_UPPER_HALF = 4'hc;
   localparam logic [PTR_W:0] PTR_ONE = 5'h01;

   // FIFO, packing and unpacking per channel
   always_comb begin
      for (int c = 0; c < NUM_CHAN; c++) begin
         full[c] = (wr_q[c][PTR_W-1:0] == rd_q[c][PTR_W-1:0])
                   && (wr_q[c][PTR_W] != rd_q[c][PTR_W]);
         empty[c] = (wr_q[c] == rd_q[c]);
         wr_d[c] = wr_q[c];
         rd_d[c] = rd_q[c];
         half_d[c] = half_q[c];
         hold_d[c] = hold_q[c];
         push[c] = 1'b0;
         pop[c] = 1'b0;
         push_data[c] = '0;
         acq_out_d[c] = acq_out_q[c];
         host_out_d[c] = host_out_q[c];
         acq_in_ready[c] = 1'b0;
         host_in_ready[c] = 1'b0;
         if (CHAN_IS_INPUT[c]) begin
            // Acquisition fills, host drains
            acq_in_ready[c] = !full[c];
            if (acq_in[c].valid && !full[c]) begin
               if (half_q[c]) begin
                  push[c] = 1'b1;
                  push_data[c] = {acq_in[c].data, hold_q[c]};
                  half_d[c] = 1'b0;
               end else begin
                  hold_d[c] = acq_in[c].data;
                  half_d[c] = 1'b1;
               end
            end
            if (host_out_q[c].valid && host_out_ready[c]) begin
               host_out_d[c].valid = 1'b0;
            end
            if ((!host_out_d[c].valid) && !empty[c] && !dma_disable[c]) begin
               pop[c] = 1'b1;
               host_out_d[c].valid = 1'b1;
               host_out_d[c].data = mem_q[c][rd_q[c][PTR_W-1:0]];
               host_out_d[c].byte_en = BE_ALL;
               host_out_d[c].last = (wr_q[c] == rd_q[c] + PTR_ONE);
            end
         end else begin
            // Host fills, acquisition drains
            host_in_ready[c] = !full[c] && !dma_disable[c];
            if (host_in[c].valid && host_in_ready[c]) begin
               push[c] = 1'b1;
               push_data[c] = host_in[c].data;
               // Unaligned head or tail: copy the valid upper half into both halves
               if (host_in[c].byte_en == BE_UPPER_HALF) begin
                  push_data[c] = {host_in[c].data[WIDE_W-1:NARROW_W],
                                  host_in[c].data[WIDE_W-1:NARROW_W]};
               end
            end
            if (acq_out_q[c].valid && acq_out_ready[c]) begin
               acq_out_d[c].valid = 1'b0;
            end
            if (!acq_out_d[c].valid && !empty[c]) begin
               acq_out_d[c].valid = 1'b1;
               acq_out_d[c].data = half_q[c] ? mem_q[c][rd_q[c][PTR_W-1:0]][WIDE_W-1:NARROW_W]
                                   : mem_q[c][rd_q[c][PTR_W-1:0]][NARROW_W-1:0];
               half_d[c] = !half_q[c];
               pop[c] = half_q[c];
            end
         end
         if (push[c]) begin
            wr_d[c] = wr_q[c] + PTR_ONE;
         end
         if (pop[c]) begin
            rd_d[c] = rd_q[c] + PTR_ONE;
         end
         // Interrupt fallback: request while ready and disabled
         irq_d[c] = irq_q[c];
         if (dma_disable[c] && (CHAN_IS_INPUT[c] ? !empty[c] : !full[c])) begin
            irq_d[c] = 1'b1;
         end else if (irq_service[c]) begin
            irq_d[c] = 1'b0;
         end
      end
   end

   // Stream slot allocation in channel order, lowest channel first
   always_comb begin
      logic [NUM_CHAN-1:0] owned;
      logic taken;
      owned = '0;
      taken = 1'b0;
      for (int s = 0; s < NUM_STREAM; s++) begin
         slot_d[s] = slot_q[s];
         if (slot_q[s] != STREAM_NONE && stream_release[slot_q[s]]) begin
            slot_d[s] = STREAM_NONE;
         end
         if (slot_d[s] != STREAM_NONE) begin
            owned[slot_d[s]] = 1'b1;
         end
      end
      err_d = '0;
      for (int c = 0; c < NUM_CHAN; c++) begin
         taken = 1'b0;
         if (stream_req[c] && !owned[c]) begin
            for (int s = 0; s < NUM_STREAM; s++) begin
               if (!taken && slot_d[s] == STREAM_NONE) begin
                  slot_d[s] = 3'(c);
                  owned[c] = 1'b1;
                  taken = 1'b1;
               end
            end
            err_d[c] = !taken;
         end
      end
      grant_d = owned;
   end

   // FIFO pointers, packing state and output words
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            wr_q[c] <= '0;
            rd_q[c] <= '0;
            hold_q[c] <= '0;
         end
         half_q <= '0;
         acq_out_q <= '0;
         host_out_q <= '0;
      end else begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            wr_q[c] <= wr_d[c];
            rd_q[c] <= rd_d[c];
            hold_q[c] <= hold_d[c];
            if (push[c]) begin
               mem_q[c][wr_q[c][PTR_W-1:0]] <= push_data[c];
            end
         end
         half_q <= half_d;
         acq_out_q <= acq_out_d;
         host_out_q <= host_out_d;
      end
   end

   // Interrupt requests
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_q <= '0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // Stream slots, grants and errors
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int s = 0; s < NUM_STREAM; s++) begin
            slot_q[s] <= STREAM_NONE;
         end
         grant_q <= '0;
         err_q <= '0;
      end else begin
         for (int s = 0; s < NUM_STREAM; s++) begin
            slot_q[s] <= slot_d[s];
         end
         grant_q <= grant_d;
         err_q <= err_d;
      end
   end

   assign acq_out = acq_out_q;
   assign host_out = host_out_q;
   assign irq_req = irq_q;
   assign stream_grant = grant_q;
   assign stream_error = err_q;
endmodule

//--- tb/dma_host_if_sva.sv
// Checker for the multichannel transfer block
// Assumes sync active-high reset; bound to the top module
`timescale 1ns/1ps
module dma_host_if_sva import dma_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Watched ports
   input wire logic [NUM_CHAN-1:0] dma_disable,
   input wire logic [NUM_CHAN-1:0] irq_req,
   input wire logic [NUM_CHAN-1:0] acq_in_ready,
   input wire logic [NUM_CHAN-1:0] host_in_ready,
   input wide_beat_type [NUM_CHAN-1:0] host_out,
   input wire logic [NUM_CHAN-1:0] host_out_ready,
   input wire logic [NUM_CHAN-1:0] stream_req,
   input wire logic [NUM_CHAN-1:0] stream_release,
   input wire logic [NUM_CHAN-1:0] stream_grant,
   input wire logic [NUM_CHAN-1:0] stream_error
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence out_held;
      host_out[0].valid && !host_out_ready[0];
   endsequence
   AST_DIR_IN: assert property ((acq_in_ready & ~CHAN_IS_INPUT) == 6'h00)
      else $error("acq ready on output channel");
   AST_DIR_OUT: assert property ((host_in_ready & CHAN_IS_INPUT) == 6'h00)
      else $error("host ready on input channel");
   AST_HOST_STAND: assert property (out_held |=> host_out[0].valid && $stable(host_out[0].data))
      else $error("host word dropped");
   AST_DIS_STALL: assert property (dma_disable[1] |-> !host_in_ready[1])
      else $error("disabled channel accepts");
   AST_IRQ_CAUSE: assert property ($rose(irq_req[0]) |-> $past(dma_disable[0]))
      else $error("irq in dma mode");
   AST_SLOTS: assert property ($countones(stream_grant) <= NUM_STREAM)
      else $error("too many slots");
   AST_GRANT_HOLD: assert property (stream_grant[0] && !stream_release[0] |=> stream_grant[0])
      else $error("slot lost");
   AST_ERR_CAUSE: assert property (stream_error[4] |-> $past(stream_req[4]) && !stream_grant[4])
      else $error("bad stream error");
endmodule
bind dma_host_if dma_host_if_sva chk (.core_clk, .rst, .dma_disable, .irq_req, .acq_in_ready,
   .host_in_ready, .host_out, .host_out_ready, .stream_req, .stream_release, .stream_grant,
   .stream_error);

//--- tb/host_mem_model.sv
// Host memory model taking packed words
// Assumes stall holds the host side back
`timescale 1ns/1ps
module host_mem_model import dma_pkg::*; (
   input wire logic core_clk,
   input wide_beat_type [NUM_CHAN-1:0] host_out,
   input wire logic [NUM_CHAN-1:0] stall,
   output logic [NUM_CHAN-1:0] host_out_ready,
   output logic [WIDE_W-1:0] got_q
);
   assign host_out_ready = ~stall;
   always_ff @(posedge core_clk) begin
      if (host_out[0].valid && host_out_ready[0]) begin
         got_q <= host_out[0].data;
      end
   end
endmodule

//--- tb/multichannel_dma_host_interface_bench.sv
// Self-checking bench for the multichannel transfer block
// Assumes the host model and checker are compiled first
`timescale 1ns/1ps
module multichannel_dma_host_interface_bench import dma_pkg::*;;
   logic core_clk, rst;
   logic [NUM_CHAN-1:0] dma_disable, irq_service, irq_req, acq_in_ready, acq_out_ready;
   logic [NUM_CHAN-1:0] host_in_ready, stall, host_out_ready, stream_req, stream_release;
   logic [NUM_CHAN-1:0] stream_grant, stream_error;
   narrow_beat_type [NUM_CHAN-1:0] acq_in, acq_out;
   wide_beat_type [NUM_CHAN-1:0] host_in, host_out;
   logic [WIDE_W-1:0] got_q;
   int n_fail = 0, total_checks = 0, cyc = 0;
   dma_host_if dut (.core_clk, .rst, .dma_disable, .irq_service, .irq_req, .acq_in,
      .acq_in_ready, .acq_out, .acq_out_ready, .host_in, .host_in_ready, .host_out,
      .host_out_ready, .stream_req, .stream_release, .stream_grant, .stream_error);
   host_mem_model host (.core_clk, .host_out, .stall, .host_out_ready, .got_q);
   initial begin
      core_clk = 0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         results();
      end
   end
   task tk(input int k);
      repeat (k) @(negedge core_clk);
   endtask
   task chk(input logic [WIDE_W-1:0] got, input logic [WIDE_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task results();
      $display("checks=%0d fails=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic t_fill();
      int n = 0;
      stall[0] = 1;
      acq_in[0] = '{1'b1, 16'h1234};
      tk(1);
      acq_in[0].data = 16'habcd;
      tk(1);
      acq_in[0].valid = 0;
      tk(2);
      chk(host_out[0].data, 32'habcd1234);
      chk(32'(host_out[0].last), 32'h1);
      chk(32'(host_out[0].byte_en), 32'hf);
      acq_in[0].valid = 1;
      while (acq_in_ready[0] === 1'b1 && n < 40) begin
         acq_in[0].data = 16'(n);
         tk(1);
         n++;
      end
      acq_in[0].valid = 0;
      chk(32'(acq_in_ready[0]), 32'h0);
      stall[0] = 0;
      tk(24);
      chk(32'(host_out[0].valid), 32'h0);
      chk(got_q, {16'(n - 1), 16'(n - 2)});
      $display("fill done");
   endtask
   task t_unpack();
      host_in[1] = '{1'b1, 1'b1, 32'h56789abc, 4'hf};
      tk(1);
      host_in[1].valid = 0;
      tk(3);
      chk(32'(acq_out[1].data), 32'h9abc);
      acq_out_ready[1] = 1;
      tk(1);
      chk(32'(acq_out[1].data), 32'h5678);
      tk(1);
      chk(32'(acq_out[1].valid), 32'h0);
      host_in[1] = '{1'b1, 1'b1, 32'h13572468, 4'hc};
      tk(1);
      host_in[1].valid = 0;
      tk(1);
      chk(32'(acq_out[1].data), 32'h1357);
      tk(1);
      chk(32'(acq_out[1].data), 32'h1357);
      $display("unpack done");
   endtask
   task automatic t_irq();
      int n = 0;
      dma_disable[1:0] = 2'h3;
      acq_in[0] = '{1'b1, 16'h0001};
      tk(2);
      acq_in[0].valid = 0;
      while (irq_req[0] !== 1'b1 && n < 8) begin
         tk(1);
         n++;
      end
      chk(32'(host_in_ready[1]), 32'h0);
      irq_service[0] = 1;
      tk(1);
      irq_service[0] = 0;
      chk(32'(irq_req[0]), 32'h1);
      dma_disable = 6'h00;
      tk(4);
      irq_service[0] = 1;
      tk(1);
      irq_service[0] = 0;
      tk(1);
      chk(32'(irq_req[0]), 32'h0);
      $display("irq done");
   endtask
   task t_stream();
      stream_req = 6'h3f;
      tk(3);
      chk(32'(stream_grant), 32'h0f);
      chk(32'(stream_error), 32'h30);
      stream_release[0] = 1;
      stream_req[0] = 0;
      tk(1);
      stream_release[0] = 0;
      tk(2);
      chk(32'(stream_grant), 32'h1e);
      $display("stream done");
   endtask
   initial begin
      rst = 1;
      {dma_disable, irq_service, acq_out_ready, stall, stream_req, stream_release} = '0;
      acq_in = '0;
      host_in = '0;
      tk(12);
      rst = 0;
      t_fill();
      t_unpack();
      t_irq();
      t_stream();
      results();
   end
endmodule
